// ### logic/adc_conversion_readout_control.v
`timescale 1ns/100ps
`include "adc_readout_defs.vh"

// What this block does
// - Ready output falls on fresh results, ignores select
// - First serial falling edge returns ready high
// - On-demand read survives next ready assertion
// - Output bit changes on rising edge, MSB first
// - Status word first, then channels ascending
// - Powered-down channel keeps slot, reads zero
// - Status word is 24 bits wide
// - Sixteen-bit results at two fastest rates
// - Extra clocks repeat frame when enabled
// - Two's complement results clip at full scale
// - Slowest low bits meaningless at fastest rates
// - Single-shot: one conversion per start, then halt
// - Single-shot ready stays low until clocked
// - Every start resets the decimation filter
// - Continuous conversions run until stopped
// - Stop lets conversion in progress finish
// - Start and stop act on seventh falling edge
// - First result waits rate-dependent settling time
// - Single-shot select is config four bit three
module adc_conversion_readout_control #(
   parameter CHANNELS = 8,
   parameter RAW_W = 26,
   parameter MCLK_DIV = 49
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Serial port from the host
   input wire sclk,
   input wire cs_n,
   input wire din,
   output reg dout,
   output wire dout_oe,
   // Conversion control pin and ready output
   input wire start_pin,
   output reg data_ready_n,
   // Configuration levels
   input wire single_conversion_mode,
   input wire multi_readback_enable,
   input wire [2:0] decimation_rate_sel,
   input wire low_power_mode,
   input wire [CHANNELS-1:0] channel_powered_down,
   // Converter results and status sources
   input wire [CHANNELS*RAW_W-1:0] raw_results,
   input wire [7:0] leadoff_status_pos,
   input wire [7:0] leadoff_status_neg,
   input wire [3:0] gpio_level,
   // Observed state
   output wire converting,
   output reg read_continuous
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SETTLE = 3'b010;
   localparam ST_RUN = 3'b100;
   localparam [7:0] DIV_LAST = MCLK_DIV - 1;
   localparam [7:0] LEN_NARROW = `STATUS_BITS + CHANNELS * `NARROW_BITS;
   localparam [7:0] LEN_WIDE = `STATUS_BITS + CHANNELS * `WIDE_BITS;

   // Synchronised pins
   wire [3:0] pin_level;
   wire [3:0] pin_rise;
   wire [3:0] pin_fall;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_low;
   wire din_s;
   wire start_level;

   // Master-clock divider
   reg [7:0] div_cnt;
   reg mclk_tick;

   // Conversion sequencing
   reg [2:0] state;
   reg [15:0] conv_cnt; // Master ticks left in this conversion
   reg stop_now; // Halt after the current result
   reg stop_late; // Halt after the next result
   reg [1:0] start_hi; // Ticks the start pin has been high
   reg [15:0] settle_ticks;
   reg [15:0] period_ticks;
   wire start_go;
   wire stop_req;
   wire result_evt;

   // Opcode receiver
   reg [6:0] cmd_sh;
   reg [2:0] cmd_bit;
   reg op_start;
   reg op_stop;
   wire [7:0] cmd_byte;

   // Frame assembly and shifting
   wire [CHANNELS*24-1:0] clipped;
   wire [`STATUS_BITS-1:0] status_word;
   wire [8*24-1:0] res_wide;
   wire [CHANNELS*24+8*24-1:0] res_pad; // Slots, then zero padding
   wire [8*16-1:0] res_narrow;
   wire [`FRAME_BITS-1:0] frame_now;
   wire narrow;
   wire [7:0] frame_len;
   reg [`FRAME_BITS-1:0] frame_hold;
   reg [`FRAME_BITS-1:0] shreg;
   reg frame_valid;
   reg [7:0] bit_idx;
   wire mid_frame;

   pin_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin({start_pin, din, cs_n, sclk}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign sclk_rise = pin_rise[0];
   assign sclk_fall = pin_fall[0];
   assign cs_low = ~pin_level[1];
   assign din_s = pin_level[2];
   assign start_level = pin_level[3];

   result_clip #(
      .CHANNELS(CHANNELS),
      .RAW_W(RAW_W)
   ) u_clip (
      .raw(raw_results),
      .channel_off(channel_powered_down),
      .clipped(clipped)
   );

   // Divider makes the converter master-clock rate as an enable
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 8'h00;
         mclk_tick <= 1'b0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= 8'h00;
         mclk_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h01;
         mclk_tick <= 1'b0;
      end
   end

   // Settling and result period chosen from rate and power mode
   always @* begin
      case ({low_power_mode, decimation_rate_sel})
         4'h0: settle_ticks = `SETTLE_HR_0;
         4'h1: settle_ticks = `SETTLE_HR_1;
         4'h2: settle_ticks = `SETTLE_HR_2;
         4'h3: settle_ticks = `SETTLE_HR_3;
         4'h4: settle_ticks = `SETTLE_HR_4;
         4'h5: settle_ticks = `SETTLE_HR_5;
         4'h8: settle_ticks = `SETTLE_LP_0;
         4'h9: settle_ticks = `SETTLE_LP_1;
         4'ha: settle_ticks = `SETTLE_LP_2;
         4'hb: settle_ticks = `SETTLE_LP_3;
         4'hc: settle_ticks = `SETTLE_LP_4;
         4'hd: settle_ticks = `SETTLE_LP_5;
         4'he: settle_ticks = `SETTLE_LP_6;
         default: settle_ticks = `SETTLE_HR_6;
      endcase
      period_ticks = low_power_mode ?
         (`PERIOD_LP_BASE << decimation_rate_sel) :
         (`PERIOD_HR_BASE << decimation_rate_sel);
   end

   // Start pin must stay high two master periods before it counts
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         start_hi <= 2'h0;
      end else if (!start_level) begin
         start_hi <= 2'h0;
      end else if (mclk_tick && start_hi != `START_MIN_TICKS) begin
         start_hi <= start_hi + 2'h1;
      end
   end

   // Qualified start edge and opcodes; any start outranks a stop
   assign start_go = op_start | (mclk_tick &&
      start_hi == `START_MIN_TICKS - 2'h1);
   assign stop_req = op_stop | pin_fall[3];
   assign result_evt = mclk_tick && state != ST_IDLE &&
      conv_cnt == 16'h0001;
   assign converting = ~state[0];

   // Conversion sequencer and ready output share one process so the
   // ready flag has a single owner
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         conv_cnt <= 16'h0000;
         stop_now <= 1'b0;
         stop_late <= 1'b0;
         data_ready_n <= 1'b1;
      end else begin
         if (start_go) begin
            // Each start restarts the filter and its settling
            state <= ST_SETTLE;
            conv_cnt <= settle_ticks;
            stop_now <= 1'b0;
            stop_late <= 1'b0;
            data_ready_n <= 1'b1;
         end else begin
            if (stop_req && state != ST_IDLE) begin
               // Too close to the result: one more conversion runs
               if (conv_cnt > `STOP_SETUP_TICKS) begin
                  stop_now <= 1'b1;
               end else begin
                  stop_late <= 1'b1;
               end
            end
            case (state)
               ST_IDLE: begin
                  conv_cnt <= 16'h0000;
               end
               ST_SETTLE, ST_RUN: begin
                  if (result_evt) begin
                     if (single_conversion_mode || stop_now) begin
                        state <= ST_IDLE;
                     end else begin
                        state <= ST_RUN;
                        conv_cnt <= period_ticks;
                        stop_now <= stop_late;
                        stop_late <= 1'b0;
                     end
                  end else if (mclk_tick) begin
                     conv_cnt <= conv_cnt - 16'h0001;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
            // Fresh results win over a clock edge in the same cycle;
            // otherwise ready holds until the host clocks
            if (result_evt) begin
               data_ready_n <= 1'b0;
            end else if (sclk_fall) begin
               data_ready_n <= 1'b1;
            end
         end
      end
   end

   // Opcode bits are taken on falling edges while selected
   assign cmd_byte = {cmd_sh, din_s};
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_sh <= 7'h00;
         cmd_bit <= 3'h0;
         op_start <= 1'b0;
         op_stop <= 1'b0;
      end else begin
         op_start <= 1'b0;
         op_stop <= 1'b0;
         if (!cs_low) begin
            cmd_bit <= 3'h0;
         end else if (sclk_fall) begin
            cmd_sh <= cmd_byte[6:0];
            cmd_bit <= cmd_bit + 3'h1;
            // Start and stop act before the final bit arrives
            if (cmd_bit == `OP_EARLY_BIT) begin
               op_start <= (cmd_byte[6:0] == `OP_START >> 1);
               op_stop <= (cmd_byte[6:0] == `OP_STOP >> 1);
            end
         end
      end
   end

   // Status word and channel slots, channel 1 leading
   assign status_word = {`STATUS_PREAMBLE, leadoff_status_pos,
      leadoff_status_neg, gpio_level};
   // Padding kept apart so an eight-channel build has no empty repeat
   assign res_pad = {clipped, {(8*24){1'b0}}};
   assign res_wide = res_pad[CHANNELS*24+8*24-1 -: 8*24];
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_narrow
         // Short words keep the top of each result
         assign res_narrow[g*16 +: 16] = res_wide[g*24+8 +: 16];
      end
   endgenerate

   // Short words only at the two fastest rates; the low bits at those
   // rates carry little information and are dropped
   assign narrow = decimation_rate_sel == `DR_FASTEST ||
      decimation_rate_sel == `DR_SECOND;
   assign frame_now = narrow ?
      {status_word, res_narrow, 64'h0} :
      {status_word, res_wide};
   assign frame_len = narrow ?
      LEN_NARROW :
      LEN_WIDE;
   assign mid_frame = bit_idx != 8'h00;
   assign dout_oe = cs_low;

   // Readout shifter: loads a snapshot, then shifts on rising edges so
   // a new result never disturbs bits already on their way out
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_hold <= {`FRAME_BITS{1'b0}};
         shreg <= {`FRAME_BITS{1'b0}};
         frame_valid <= 1'b0;
         bit_idx <= 8'h00;
         dout <= 1'b0;
         read_continuous <= 1'b1;
      end else begin
         if (result_evt && !mid_frame) begin
            frame_hold <= frame_now;
            if (read_continuous) begin
               shreg <= frame_now;
               frame_valid <= 1'b1;
            end
         end
         if (!cs_low && mid_frame) begin
            // A cut frame restarts from its top on the next select
            bit_idx <= 8'h00;
            shreg <= frame_hold;
         end
         if (cs_low && sclk_fall && cmd_bit == `OP_LAST_BIT) begin
            if (cmd_byte == `OP_READ_ONCE) begin
               shreg <= frame_hold;
               frame_valid <= 1'b1;
            end
            if (cmd_byte == `OP_READ_CONT) begin
               read_continuous <= 1'b1;
            end
            if (cmd_byte == `OP_STOP_READ_CONT) begin
               read_continuous <= 1'b0;
            end
         end
         if (cs_low && sclk_rise && frame_valid) begin
            dout <= shreg[`FRAME_BITS-1];
            shreg <= {shreg[`FRAME_BITS-2:0], 1'b0};
            if (bit_idx == frame_len - 8'h01) begin
               bit_idx <= 8'h00;
               if (multi_readback_enable) begin
                  shreg <= frame_hold;
               end else begin
                  frame_valid <= 1'b0;
               end
            end else begin
               bit_idx <= bit_idx + 8'h01;
            end
         end else if (!frame_valid) begin
            dout <= 1'b0;
         end
      end
   end

endmodule

// ### logic/adc_readout_defs.vh
`ifndef ADC_READOUT_DEFS_VH
`define ADC_READOUT_DEFS_VH

// Frame geometry
`define STATUS_BITS 24
`define WIDE_BITS 24
`define NARROW_BITS 16
`define MAX_CHANNELS 8
`define FRAME_BITS 216
`define STATUS_PREAMBLE 4'hc

// Clipping codes of a 24-bit two's-complement result
`define CODE_MAX 24'h7fffff
`define CODE_MIN 24'h800000

// Rate selections that give the short result words
`define DR_FASTEST 3'h0
`define DR_SECOND 3'h1

// Opcodes (full byte); start and stop decode on seven bits
`define OP_START 8'h08
`define OP_STOP 8'h0a
`define OP_READ_CONT 8'h10
`define OP_STOP_READ_CONT 8'h11
`define OP_READ_ONCE 8'h12
`define OP_EARLY_BIT 3'h6
`define OP_LAST_BIT 3'h7

// Timing in master-clock periods
`define START_MIN_TICKS 2'h2
`define STOP_SETUP_TICKS 16'h0010
`define PERIOD_HR_BASE 16'h0040
`define PERIOD_LP_BASE 16'h0080

// First-result settling, high-resolution operation
`define SETTLE_HR_0 16'h0128
`define SETTLE_HR_1 16'h0248
`define SETTLE_HR_2 16'h0488
`define SETTLE_HR_3 16'h0908
`define SETTLE_HR_4 16'h1208
`define SETTLE_HR_5 16'h2408
`define SETTLE_HR_6 16'h4808

// First-result settling, low-power operation
`define SETTLE_LP_0 16'h0248
`define SETTLE_LP_1 16'h0488
`define SETTLE_LP_2 16'h0908
`define SETTLE_LP_3 16'h1208
`define SETTLE_LP_4 16'h2408
`define SETTLE_LP_5 16'h4808
`define SETTLE_LP_6 16'h9008

`endif

// ### logic/pin_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for a group of pin inputs, with edge detection
// taken only from the second stage.
module pin_sync #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Raw pins
   input wire [WIDTH-1:0] pin,
   // Synchronised level and edges
   output reg [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);

   reg [WIDTH-1:0] meta; // First stage, read by the second stage only
   reg [WIDTH-1:0] prev; // Last level, for edge detection

   // Shift the pins through two stages and keep one older sample
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= {WIDTH{1'b0}};
         level <= {WIDTH{1'b0}};
         prev <= {WIDTH{1'b0}};
      end else begin
         meta <= pin;
         level <= meta;
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule

// ### logic/result_clip.v
`timescale 1ns/100ps
`include "adc_readout_defs.vh"
// Saturates raw filter outputs to 24-bit two's complement and zeroes
// the slots of powered-down channels.
module result_clip #(
   parameter CHANNELS = 8,
   parameter RAW_W = 26
) (
   // Raw signed results, channel 1 in the top slot
   input wire [CHANNELS*RAW_W-1:0] raw,
   // Per-channel power-down, bit 0 is channel 1
   input wire [CHANNELS-1:0] channel_off,
   // Clipped results, channel 1 in the top slot
   output wire [CHANNELS*24-1:0] clipped
);

   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
         wire [RAW_W-1:0] r;
         wire over; // Above largest positive code
         wire under; // Below most negative code
         assign r = raw[(CHANNELS-1-i)*RAW_W +: RAW_W];
         // Upper bits must all equal the 24-bit sign, else out of range
         assign over = ~r[RAW_W-1] & (|r[RAW_W-2:23]);
         assign under = r[RAW_W-1] & ~(&r[RAW_W-2:23]);
         assign clipped[(CHANNELS-1-i)*24 +: 24] =
            channel_off[i] ? 24'h000000 :
            over ? `CODE_MAX :
            under ? `CODE_MIN :
            r[23:0];
      end
   endgenerate

endmodule

// ### tb/adc_host_model.sv
`timescale 1ns/100ps
// Host master on the serial port; clock parked low between frames
module adc_host_model (
   // Serial lines
   output logic sclk,
   output logic cs_n,
   output logic din,
   input logic dout
);
   // Deselected and quiet at start
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b1;
   end
   // n bits, opcode first; zeros follow while reading
   task automatic xfer(input logic [7:0] op, input int n,
         output logic [255:0] rx);
      int i;
      cs_n = 1'b0;
      rx = '0;
      for (i = 0; i < n; i++) begin
         din = (i < 8) ? op[7-i] : 1'b0;
         #20 sclk = 1'b1;
         #60 rx = {rx[254:0], dout};
         sclk = 1'b0;
         #80;
      end
   endtask
   // Deselect; the gap covers opcode decode time
   task automatic idle();
      #40 cs_n = 1'b1;
      din = ~din;
      #100;
   endtask
   // Ungated pulse, as if talking to another device
   task automatic tick();
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
      #80;
   endtask
endmodule

// ### tb/adc_conversion_readout_control_asserts.sv
`timescale 1ns/100ps
// Port-level timing checks of the readout control
module adc_conversion_readout_control_asserts #(
   parameter CHANNELS = 8,
   parameter RAW_W = 26,
   parameter MCLK_DIV = 49
) (
   // Clock and reset
   input logic clk,
   input logic reset_n,
   // Pins and levels
   input logic sclk,
   input logic cs_n,
   input logic dout,
   input logic dout_oe,
   input logic start_pin,
   input logic data_ready_n,
   input logic single_conversion_mode,
   input logic converting,
   input logic read_continuous
);
   // Shortest first-result wait, one tick of slack for sync phase
   localparam int settle_min = 295 * MCLK_DIV;
   // Start needs two ticks plus pin sync
   localparam int start_max = 3 * MCLK_DIV + 4;
   logic [3:0] fall_age; // Clocks since an sclk fall
   logic [15:0] conv_age; // Clocks since conversions began
   logic first; // No result yet since conversions began
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Helper counters, both saturating
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fall_age <= 4'hf;
         conv_age <= 16'h0000;
         first <= 1'b0;
      end else begin
         fall_age <= $fell(sclk) ? 4'h0 :
            fall_age + {3'h0, fall_age != 4'hf};
         conv_age <= $rose(converting) ? 16'h0000 :
            conv_age + {15'h0, conv_age != 16'hffff};
         first <= $rose(converting) | (first & data_ready_n);
      end
   end
   sequence pin_held;
      $rose(start_pin) ##1 start_pin [*7];
   endsequence
   sequence ready_back;
      ##[1:6] data_ready_n;
   endsequence
   AST_RESET_IDLE: assert property ($rose(reset_n) |->
      data_ready_n && !converting && read_continuous && !dout)
      else $error("outputs not idle after reset");
   AST_OE_SELECT: assert property ($stable(cs_n) [*4] |->
      dout_oe == !cs_n) else $error("dout_oe does not follow cs_n");
   AST_DOUT_ON_RISE: assert property (
      $changed(dout) && !cs_n |-> sclk)
      else $error("dout moved while sclk low");
   AST_READY_CLEAR: assert property (
      $fell(sclk) && !data_ready_n |-> ready_back)
      else $error("sclk fall left ready low");
   AST_READY_CAUSE: assert property ($rose(data_ready_n) |->
      (fall_age < 4'h7) or (##[0:2] converting))
      else $error("ready rose with no sclk fall or start");
   AST_READY_FROM_CONV: assert property (
      $fell(data_ready_n) |-> $past(converting))
      else $error("ready fell with no conversion");
   AST_SINGLE_HALT: assert property (
      single_conversion_mode && $fell(data_ready_n)
      |-> ##[0:4] !converting) else $error("single shot kept running");
   AST_START_PIN: assert property (
      pin_held |-> ##[0:start_max] converting)
      else $error("start pin did not start conversions");
   AST_SETTLE: assert property (
      $fell(data_ready_n) && first |-> conv_age >= settle_min)
      else $error("first result came before settling");
endmodule

bind adc_conversion_readout_control adc_conversion_readout_control_asserts
   #(.CHANNELS(CHANNELS), .RAW_W(RAW_W), .MCLK_DIV(MCLK_DIV)) u_watch (
   .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
   .dout(dout), .dout_oe(dout_oe), .start_pin(start_pin),
   .data_ready_n(data_ready_n),
   .single_conversion_mode(single_conversion_mode),
   .converting(converting), .read_continuous(read_continuous));

// ### tb/adc_conversion_readout_control_test.sv
`timescale 1ns/100ps
`include "adc_readout_defs.vh"
module adc_conversion_readout_control_test;
   // Clock, reset and pins
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sclk, cs_n, din, dout, dout_oe, data_ready_n;
   logic converting, read_continuous;
   logic start_pin = 1'b0;
   // Configuration levels
   logic single_conversion_mode = 1'b1;
   logic multi_readback_enable = 1'b0;
   logic [2:0] decimation_rate_sel = 3'h2;
   logic [7:0] channel_powered_down = 8'h00;
   // Channel 1 on top; two lie beyond full scale
   logic [207:0] raw_results = {26'h1000000, 26'h2ffffff, 26'h0123456,
      26'h3ffffff, 26'h07fffff, 26'h3800000, 26'h00abcde, 26'h3f00000};
   localparam logic [23:0] status_word = {`STATUS_PREAMBLE, 8'ha5,
      8'h3c, 4'h9};
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   int i, n, w;
   logic [255:0] rx, ex;
   // Row: rate, powered-down mask, repeat enable, frame bits
   typedef struct {logic [2:0] dr; logic [7:0] pd; logic mrb;
      int bits;} row_t;
   row_t rows [3] = '{'{3'h2, 8'h00, 1'b1, 216},
      '{3'h0, 8'h05, 1'b0, 152}, '{3'h1, 8'h80, 1'b1, 152}};
   // Short master-clock divider keeps the run brief
   adc_conversion_readout_control #(.MCLK_DIV(2)) DUT (
      .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .din(din), .dout(dout), .dout_oe(dout_oe), .start_pin(start_pin),
      .data_ready_n(data_ready_n),
      .single_conversion_mode(single_conversion_mode),
      .multi_readback_enable(multi_readback_enable),
      .decimation_rate_sel(decimation_rate_sel), .low_power_mode(1'b0),
      .channel_powered_down(channel_powered_down),
      .raw_results(raw_results), .leadoff_status_pos(8'ha5),
      .leadoff_status_neg(8'h3c), .gpio_level(4'h9),
      .converting(converting), .read_continuous(read_continuous));
   adc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   // 100 MHz clock; reset for 12 cycles
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         tally_and_finish();
      end
   end
   // Inputs move 1 ns after the edge
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic [255:0] e,
         input logic [255:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, e, g);
      end
   endtask
   // Bounded wait for a fresh result
   task automatic wait_ready(input int lim);
      int k;
      for (k = 0; k < lim && data_ready_n !== 1'b0; k++) step(1);
      check("ready low", 0, data_ready_n);
   endtask
   // Saturate a raw result to 24 bits
   function automatic logic [23:0] clip(input logic [25:0] r);
      if (r[25:23] == 3'b000 || r[25:23] == 3'b111) return r[23:0];
      return r[25] ? 24'h800000 : 24'h7fffff;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      step(1);
      check("reset", 4'h5, {dout, data_ready_n, converting,
         read_continuous});
      @(posedge reset_n);
      step(4);
      // Single-shot captures and readouts, one per row
      foreach (rows[r]) begin
         decimation_rate_sel = rows[r].dr;
         channel_powered_down = rows[r].pd;
         multi_readback_enable = rows[r].mrb;
         start_pin = 1'b1;
         step(10);
         start_pin = 1'b0;
         wait_ready(6000);
         step(100);
         check("ready held", 0, data_ready_n);
         w = rows[r].bits == 152 ? 16 : 24;
         ex = status_word;
         for (i = 0; i < 8; i++) begin
            ex = (ex << w) | 256'(rows[r].pd[i] ? 24'h0 :
               clip(raw_results[207-26*i -: 26]) >> (24 - w));
         end
         ex = (ex << 24) | 256'(rows[r].mrb ? status_word : 24'h0);
         host.xfer(8'h00, rows[r].bits + 24, rx);
         host.idle();
         check("frame", ex, rx);
         check("ready cleared", 1, data_ready_n);
         step(20);
         check("halted", 0, converting);
         $display("test row %0d done", r);
      end
      // Start opcode acts on its seventh falling edge
      decimation_rate_sel = 3'h0;
      host.xfer(`OP_START, 6, rx);
      step(16);
      check("six edges", 0, converting);
      host.xfer(8'(`OP_START << 6), 1, rx);
      step(16);
      check("seven edges", 1, converting);
      host.idle();
      wait_ready(2000);
      host.tick();
      check("cleared deselected", 1, data_ready_n);
      $display("test opcode edge done");
      // Continuous run stopped by opcode shortly after a result
      single_conversion_mode = 1'b0;
      decimation_rate_sel = 3'h1;
      host.xfer(`OP_STOP, 8, rx);
      host.idle();
      host.xfer(`OP_START, 8, rx);
      host.idle();
      for (i = 0; i < 2; i++) begin
         wait_ready(3000);
         host.tick();
      end
      host.xfer(`OP_STOP, 8, rx);
      host.idle();
      n = 0;
      repeat (1500) begin
         step(1);
         if (data_ready_n === 1'b0) begin
            n++;
            host.tick();
         end
      end
      check("results after stop", 1, n);
      check("stopped", 0, converting);
      $display("test continuous done");
      // Continuous-read mode off and back on
      for (i = 0; i < 2; i++) begin
         host.xfer(i ? `OP_READ_CONT : `OP_STOP_READ_CONT, 8, rx);
         host.idle();
         step(8);
         check("read mode", i, read_continuous);
      end
      $display("test read mode done");
      tally_and_finish();
   end
endmodule
